//--- src/cfg_msg_pkg.sv
// Constants, token and request carriers for the configuration message handler.
// Assumes 8-bit tokens with a control flag, as carried by the token interconnect.
package cfg_msg_pkg;

  // Control token values of the request and reply messages
  localparam logic [7:0] TOK_CFG_WRITE   = 8'hC0;
  localparam logic [7:0] TOK_CFG_READ    = 8'hC1;
  localparam logic [7:0] TOK_PERIPH_WR   = 8'h24;
  localparam logic [7:0] TOK_PERIPH_RD   = 8'h25;
  localparam logic [7:0] TOK_ACK         = 8'h03;
  localparam logic [7:0] TOK_NACK        = 8'h04;
  localparam logic [7:0] TOK_END         = 8'h01;

  // Processor-status resource identifier: number shifted up, low byte merged
  localparam int         PS_SHIFT        = 8;
  localparam logic [7:0] PS_LOW_BYTE     = 8'h0C;

  // Field lengths in bytes, and the default peripheral register count
  localparam logic [7:0] RID_BYTES       = 8'h03;
  localparam logic [7:0] CFG_REG_BYTES   = 8'h02;
  localparam logic [7:0] WORD_BYTES      = 8'h04;
  localparam int         PERIPH_REG_MAX  = 256;

  typedef struct packed {
    logic       ctrl;
    logic [7:0] data;
  } token_s;

  typedef enum logic [1:0] {
    KIND_CFG    = 2'h0,
    KIND_PERIPH = 2'h1,
    KIND_PS     = 2'h2
  } kind_e;

  typedef struct packed {
    kind_e       kind;
    logic        write;
    logic [15:0] regNum;
    logic [7:0]  size;
    logic [31:0] wdata;
  } acc_s;

  // Gray codes along the usual receive, access, reply path
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_RID    = 4'h1,
    ST_REG    = 4'h3,
    ST_SIZE   = 4'h2,
    ST_DATA   = 4'h6,
    ST_ENDW   = 4'h7,
    ST_ACCESS = 4'h5,
    ST_RHEAD  = 4'h4,
    ST_RDATA  = 4'hC,
    ST_REND   = 4'hD,
    ST_DRAIN  = 4'hF
  } state_e;

endpackage

//--- src/config_register_message_handler.sv
// Configuration message handler: parses request tokens, runs one register
// access on the back-end port, and streams the reply tokens.
// Assumes one clock, synchronous token streams and a back-end that answers
// every access with a one-cycle done strobe.
`timescale 1ns/1ps
module config_register_message_handler #(
  parameter int PERIPH_REG_COUNT = cfg_msg_pkg::PERIPH_REG_MAX
) (
  input  wire logic                ref_clk,
  input  wire logic                rst_b,
  input  wire logic                ce,
  input  wire logic                inValid,
  input  wire cfg_msg_pkg::token_s inTok,
  output logic                     inReady,
  output logic                     outValid,
  output cfg_msg_pkg::token_s      outTok,
  output logic [23:0]              outDest,
  input  wire logic                outReady,
  input  wire logic                psValid,
  input  wire logic                psWrite,
  input  wire logic [7:0]          psReg,
  input  wire logic [31:0]         psWdata,
  output logic                     psReady,
  output logic                     psDone,
  output logic [31:0]              psRdata,
  output logic                     accValid,
  output cfg_msg_pkg::acc_s        acc,
  input  wire logic                accDone,
  input  wire logic                accErr,
  input  wire logic [31:0]         accRdata
);

  cfg_msg_pkg::state_e st_r;
  cfg_msg_pkg::kind_e  kind_r;
  logic                write_r;
  logic                fail_r;
  logic                haveRid_r;
  logic [7:0]          cnt_r;
  logic [23:0]         rid_r;
  logic [15:0]         reg_r;
  logic [7:0]          size_r;
  logic [31:0]         dat_r;
  logic [31:0]         psRdata_r;

  // Handshake decode
  wire inAcc    = inValid && inReady;
  wire outAcc   = outValid && outReady && ce;
  wire isEnd    = inTok.ctrl && (inTok.data == cfg_msg_pkg::TOK_END);
  wire isPeriph = (kind_r == cfg_msg_pkg::KIND_PERIPH);
  wire hdrCfgWr = inTok.ctrl && (inTok.data == cfg_msg_pkg::TOK_CFG_WRITE);
  wire hdrCfgRd = inTok.ctrl && (inTok.data == cfg_msg_pkg::TOK_CFG_READ);
  wire hdrPerWr = inTok.ctrl && (inTok.data == cfg_msg_pkg::TOK_PERIPH_WR);
  wire hdrPerRd = inTok.ctrl && (inTok.data == cfg_msg_pkg::TOK_PERIPH_RD);
  wire hdrAny   = hdrCfgWr || hdrCfgRd || hdrPerWr || hdrPerRd;
  // Size 1..4 and register inside the implemented range
  wire rangeBad = isPeriph && ((size_r == 8'h00) || (size_r > cfg_msg_pkg::WORD_BYTES) ||
                  (32'(reg_r[7:0]) >= PERIPH_REG_COUNT));
  // Read data is left-justified so the reply always takes the top byte
  wire [2:0] padBytes = 3'(cfg_msg_pkg::WORD_BYTES) - size_r[2:0];
  wire [5:0] rdShift  = {padBytes, 3'b000};
  wire [15:0] psResId = (16'(psReg) << cfg_msg_pkg::PS_SHIFT) |
                        {8'h00, cfg_msg_pkg::PS_LOW_BYTE};

  // Port decode; ready terms carry ce so a frozen block takes nothing
  assign inReady  = ce && (st_r inside {cfg_msg_pkg::ST_IDLE, cfg_msg_pkg::ST_RID,
                    cfg_msg_pkg::ST_REG, cfg_msg_pkg::ST_SIZE, cfg_msg_pkg::ST_DATA,
                    cfg_msg_pkg::ST_ENDW, cfg_msg_pkg::ST_DRAIN});
  assign psReady  = ce && (st_r == cfg_msg_pkg::ST_IDLE) && !inValid;
  assign outValid = st_r inside {cfg_msg_pkg::ST_RHEAD, cfg_msg_pkg::ST_RDATA,
                    cfg_msg_pkg::ST_REND};
  assign accValid = (st_r == cfg_msg_pkg::ST_ACCESS);
  assign psDone   = ce && accValid && accDone && (kind_r == cfg_msg_pkg::KIND_PS);
  assign psRdata  = psRdata_r;
  assign outDest  = rid_r;
  assign acc      = '{kind: kind_r, write: write_r, regNum: reg_r, size: size_r,
                      wdata: dat_r};

  // Reply token select from flops; one driver for the whole struct
  wire       replyCtrl = (st_r != cfg_msg_pkg::ST_RDATA);
  wire [7:0] replyData = (st_r == cfg_msg_pkg::ST_RHEAD) ?
                         (fail_r ? cfg_msg_pkg::TOK_NACK : cfg_msg_pkg::TOK_ACK) :
                         (st_r == cfg_msg_pkg::ST_RDATA) ? dat_r[31:24] :
                         cfg_msg_pkg::TOK_END;
  assign outTok = '{ctrl: replyCtrl, data: replyData};

  // Message sequencer
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r      <= cfg_msg_pkg::ST_IDLE;
      kind_r    <= cfg_msg_pkg::KIND_CFG;
      write_r   <= 1'b0;
      fail_r    <= 1'b0;
      haveRid_r <= 1'b0;
      cnt_r     <= 8'h00;
      rid_r     <= 24'h000000;
      reg_r     <= 16'h0000;
      size_r    <= 8'h00;
      dat_r     <= 32'h00000000;
      psRdata_r <= 32'h00000000;
    end else if (ce) begin
      case (st_r)
        cfg_msg_pkg::ST_IDLE: begin
          if (inAcc && hdrAny) begin
            kind_r    <= (hdrPerWr || hdrPerRd) ? cfg_msg_pkg::KIND_PERIPH :
                         cfg_msg_pkg::KIND_CFG;
            write_r   <= hdrCfgWr || hdrPerWr;
            size_r    <= cfg_msg_pkg::WORD_BYTES;
            fail_r    <= 1'b0;
            haveRid_r <= 1'b0;
            dat_r     <= 32'h00000000;
            cnt_r     <= cfg_msg_pkg::RID_BYTES - 8'h01;
            st_r      <= cfg_msg_pkg::ST_RID;
          end else if (inAcc && inTok.ctrl && !isEnd) begin
            haveRid_r <= 1'b0;                                            // Unknown: no reply
            st_r      <= cfg_msg_pkg::ST_DRAIN;
          end else if (psValid && psReady) begin
            kind_r  <= cfg_msg_pkg::KIND_PS;
            write_r <= psWrite;
            reg_r   <= psResId;
            size_r  <= cfg_msg_pkg::WORD_BYTES;
            dat_r   <= psWdata;
            st_r    <= cfg_msg_pkg::ST_ACCESS;
          end
        end
        cfg_msg_pkg::ST_RID, cfg_msg_pkg::ST_REG, cfg_msg_pkg::ST_SIZE,
        cfg_msg_pkg::ST_DATA: begin
          if (inAcc && inTok.ctrl) begin
            // Early control token: the message is cut short and fails
            fail_r <= 1'b1;
            st_r   <= !isEnd ? cfg_msg_pkg::ST_DRAIN :
                      (haveRid_r ? cfg_msg_pkg::ST_RHEAD : cfg_msg_pkg::ST_IDLE);
          end else if (inAcc) begin
            cnt_r <= cnt_r - 8'h01;
            case (st_r)
              cfg_msg_pkg::ST_RID: begin
                rid_r <= {rid_r[15:0], inTok.data};
                if (cnt_r == 8'h00) begin
                  haveRid_r <= 1'b1;
                  cnt_r <= isPeriph ? 8'h00 : cfg_msg_pkg::CFG_REG_BYTES - 8'h01;
                  st_r  <= cfg_msg_pkg::ST_REG;
                end
              end
              cfg_msg_pkg::ST_REG: begin
                reg_r <= isPeriph ? {8'h00, inTok.data} : {reg_r[7:0], inTok.data};
                if (cnt_r == 8'h00) begin
                  cnt_r <= cfg_msg_pkg::WORD_BYTES - 8'h01;
                  st_r  <= isPeriph ? cfg_msg_pkg::ST_SIZE :
                           (write_r ? cfg_msg_pkg::ST_DATA : cfg_msg_pkg::ST_ENDW);
                end
              end
              cfg_msg_pkg::ST_SIZE: begin
                size_r <= inTok.data;
                cnt_r  <= inTok.data - 8'h01;
                st_r   <= (write_r && inTok.data != 8'h00) ? cfg_msg_pkg::ST_DATA :
                          cfg_msg_pkg::ST_ENDW;
              end
              default: begin
                dat_r <= {dat_r[23:0], inTok.data};
                if (cnt_r == 8'h00) begin
                  st_r <= cfg_msg_pkg::ST_ENDW;
                end
              end
            endcase
          end
        end
        cfg_msg_pkg::ST_ENDW: begin
          if (inAcc && isEnd) begin
            fail_r <= rangeBad;
            st_r   <= rangeBad ? cfg_msg_pkg::ST_RHEAD : cfg_msg_pkg::ST_ACCESS;
          end else if (inAcc) begin
            fail_r <= 1'b1;                                               // Overlong message
            st_r   <= cfg_msg_pkg::ST_DRAIN;
          end
        end
        cfg_msg_pkg::ST_ACCESS: begin
          if (accDone) begin
            if (kind_r == cfg_msg_pkg::KIND_PS) begin
              psRdata_r <= accRdata;
              st_r      <= cfg_msg_pkg::ST_IDLE;
            end else begin
              fail_r <= accErr;
              dat_r  <= accRdata << rdShift;
              cnt_r  <= size_r - 8'h01;
              st_r   <= cfg_msg_pkg::ST_RHEAD;
            end
          end
        end
        cfg_msg_pkg::ST_RHEAD: begin
          if (outAcc) begin
            st_r <= (!fail_r && !write_r) ? cfg_msg_pkg::ST_RDATA :
                    cfg_msg_pkg::ST_REND;
          end
        end
        cfg_msg_pkg::ST_RDATA: begin
          if (outAcc) begin
            dat_r <= {dat_r[23:0], 8'h00};
            cnt_r <= cnt_r - 8'h01;
            if (cnt_r == 8'h00) begin
              st_r <= cfg_msg_pkg::ST_REND;
            end
          end
        end
        cfg_msg_pkg::ST_REND: begin
          if (outAcc) begin
            st_r <= cfg_msg_pkg::ST_IDLE;
          end
        end
        cfg_msg_pkg::ST_DRAIN: begin
          if (inAcc && isEnd) begin
            st_r <= haveRid_r ? cfg_msg_pkg::ST_RHEAD : cfg_msg_pkg::ST_IDLE;
          end
        end
        default: begin
          st_r <= cfg_msg_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Reply and access checks
  sequence s_failHead;
    outAcc && (st_r == cfg_msg_pkg::ST_RHEAD) && fail_r;
  endsequence
  sequence s_endTok;
    outValid && outTok.ctrl && (outTok.data == cfg_msg_pkg::TOK_END);
  endsequence

  property p_headTok;
    @(posedge ref_clk) disable iff (!rst_b)
    (st_r == cfg_msg_pkg::ST_RHEAD) |-> outTok.ctrl &&
      (outTok.data == (fail_r ? cfg_msg_pkg::TOK_NACK : cfg_msg_pkg::TOK_ACK));
  endproperty
  a_headTok: assert property (p_headTok) else $error("bad reply head token");

  property p_failEnd;
    @(posedge ref_clk) disable iff (!rst_b)
    s_failHead |=> s_endTok;
  endproperty
  a_failEnd: assert property (p_failEnd) else $error("failure not closed by end");

  property p_readData;
    @(posedge ref_clk) disable iff (!rst_b)
    (outAcc && st_r == cfg_msg_pkg::ST_RHEAD && !fail_r && !write_r && !isPeriph)
      |=> (st_r == cfg_msg_pkg::ST_RDATA) && (cnt_r == 8'h03) && !outTok.ctrl;
  endproperty
  a_readData: assert property (p_readData) else $error("read reply lacks data");

  property p_reqAfterEnd;
    @(posedge ref_clk) disable iff (!rst_b)
    $rose(accValid) && kind_r != cfg_msg_pkg::KIND_PS |-> $past(inAcc && isEnd);
  endproperty
  a_reqAfterEnd: assert property (p_reqAfterEnd) else $error("access before end");

  property p_psResId;
    @(posedge ref_clk) disable iff (!rst_b)
    accValid && kind_r == cfg_msg_pkg::KIND_PS |-> acc.regNum[7:0] == cfg_msg_pkg::PS_LOW_BYTE;
  endproperty
  a_psResId: assert property (p_psResId) else $error("bad status resource id");

  property p_psWord;
    @(posedge ref_clk) disable iff (!rst_b)
    psDone |=> (psRdata == $past(accRdata)) && (st_r == cfg_msg_pkg::ST_IDLE);
  endproperty
  a_psWord: assert property (p_psWord) else $error("status word not returned");

  property p_periphRange;
    @(posedge ref_clk) disable iff (!rst_b)
    accValid && isPeriph |-> (acc.size != 8'h00) && (acc.size <= cfg_msg_pkg::WORD_BYTES);
  endproperty
  a_periphRange: assert property (p_periphRange) else $error("bad size accessed");

  property p_readNoData;
    @(posedge ref_clk) disable iff (!rst_b)
    (st_r == cfg_msg_pkg::ST_DATA) |-> write_r;
  endproperty
  a_readNoData: assert property (p_readNoData) else $error("read took data");

  property p_outHold;
    @(posedge ref_clk) disable iff (!rst_b)
    outValid && !outReady |=> outValid && $stable(outTok);
  endproperty
  a_outHold: assert property (p_outHold) else $error("reply token dropped");

endmodule // config_register_message_handler

//--- tb/req_end.sv
// Requester channel-end model: sends request tokens, collects reply tokens.
// Assumes the bench calls send and idle; replies pile up in got, {dest, token}.
`timescale 1ns/1ps
module req_end (
  input  wire logic                ref_clk,
  input  wire logic                ce,
  input  wire logic                inReady,
  input  wire logic                outValid,
  input  wire cfg_msg_pkg::token_s outTok,
  input  wire logic [23:0]         outDest,
  output logic                     inValid,
  output cfg_msg_pkg::token_s      inTok,
  output logic                     outReady
);
  logic [32:0] got [$];
  int          seed = 42555;

  initial begin
    inValid  = 1'h0;
    inTok    = 9'h101;
    outReady = 1'h0;
  end

  // Token held from a falling edge to the rising edge that finds ready high
  task automatic send(input logic c, input logic [7:0] d);
    @(negedge ref_clk);
    inValid = 1'h1;
    inTok   = {c, d};
    do @(posedge ref_clk); while (!inReady);
  endtask

  // Released line flips, so a stale token never looks valid
  task automatic idle();
    @(negedge ref_clk);
    inValid = 1'h0;
    inTok   = ~inTok;
  endtask

  // Reply sink stalls one cycle in four; routing to C20C, C30C, pp02 is the fabric's
  always @(negedge ref_clk) outReady <= ($random(seed) % 4) != 0;
  always @(posedge ref_clk) if (outValid && outReady && ce) got.push_back({outDest, outTok});
endmodule // req_end

//--- tb/test_config_register_message_handler.sv
// Bench for the configuration message handler: corner and random requests.
// Assumes req_end as the requester and a register back-end modelled here.
`timescale 1ns/1ps
module test_config_register_message_handler;
  localparam int REGS = 200;
  logic                ref_clk  = 1'h0;
  logic                rst_b    = 1'h0;
  logic                ce       = 1'h1;
  logic                inValid;
  cfg_msg_pkg::token_s inTok;
  logic                inReady;
  logic                outValid;
  cfg_msg_pkg::token_s outTok;
  logic [23:0]         outDest;
  logic                outReady;
  logic                psValid  = 1'h0;
  logic                psWrite  = 1'h0;
  logic [7:0]          psReg    = 8'h00;
  logic [31:0]         psWdata  = 32'h0;
  logic                psReady;
  logic                psDone;
  logic [31:0]         psRdata;
  logic                accValid;
  cfg_msg_pkg::acc_s   acc;
  logic                accDone  = 1'h0;
  logic                accErr   = 1'h0;
  logic [31:0]         accRdata = 32'h0;
  logic                errNext  = 1'h0;
  logic [31:0]         refm [int];
  logic [31:0]         bmem [int];
  logic [32:0]         exp [$];
  logic [31:0]         r;
  logic [7:0]          rb;
  int                  fails    = 0;
  int                  nTests   = 0;
  int                  cyc      = 0;
  int                  seed     = 42555;
  logic [7:0]          hdr [4]  = '{cfg_msg_pkg::TOK_CFG_WRITE, cfg_msg_pkg::TOK_CFG_READ,
                                    cfg_msg_pkg::TOK_PERIPH_WR, cfg_msg_pkg::TOK_PERIPH_RD};

  always #2.5 ref_clk = ~ref_clk;

  config_register_message_handler #(.PERIPH_REG_COUNT(REGS)) DUT (
    .ref_clk(ref_clk), .rst_b(rst_b), .ce(ce), .inValid(inValid), .inTok(inTok),
    .inReady(inReady), .outValid(outValid), .outTok(outTok), .outDest(outDest),
    .outReady(outReady), .psValid(psValid), .psWrite(psWrite), .psReg(psReg),
    .psWdata(psWdata), .psReady(psReady), .psDone(psDone), .psRdata(psRdata),
    .accValid(accValid), .acc(acc), .accDone(accDone), .accErr(accErr), .accRdata(accRdata));

  req_end chan (
    .ref_clk(ref_clk), .ce(ce), .inReady(inReady), .outValid(outValid), .outTok(outTok),
    .outDest(outDest), .inValid(inValid), .inTok(inTok), .outReady(outReady));

  // Back-end answers after a random wait; a done strobe only lands while running
  always @(negedge ref_clk) begin
    rb = 8'($random(seed));
    ce <= rb[2:0] != 3'h0;
    accDone <= 1'h0;
    if (accValid && !accDone && rb[2:0] != 3'h0 && rb[3]) begin
      accDone  <= 1'h1;
      accErr   <= errNext;
      accRdata <= bmem.exists(acc.regNum) ? bmem[acc.regNum] : 32'h0;
      if (acc.write && !errNext) bmem[acc.regNum] = acc.wdata;
    end
  end

  // Hang guard, far above the few thousand cycles the run needs
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      summarize();
    end
  end

  function automatic logic [31:0] rd(input int k);
    return refm.exists(k) ? refm[k] : 32'h0;
  endfunction

  // Low n bytes only: narrow peripheral transfers are right-justified
  function automatic logic [31:0] low(input logic [31:0] v, input int n);
    return (n >= 4) ? v : v & ((32'h1 << (8 * n)) - 32'h1);
  endfunction

  task automatic cmpTok(input string nm, input logic [32:0] e, input logic [32:0] s);
    nTests++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic cmpWord(input string nm, input logic [31:0] e, input logic [31:0] s);
    nTests++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic drain();
    for (int k = 0; k < 400 && chan.got.size() < exp.size(); k++) @(posedge ref_clk);
    while (exp.size() > 0) cmpTok("reply token", exp.pop_front(), chan.got.size() > 0 ?
                                  chan.got.pop_front() : {33{1'bx}});
    cmpWord("leftover tokens", 32'h0, 32'(chan.got.size()));
  endtask

  // op: 0 config write, 1 config read, 2 peripheral write, 3 peripheral read
  task automatic msg(input logic [1:0] op, input logic [15:0] rg, input logic [7:0] sz,
                     input logic [31:0] dat);
    logic [23:0] rid;
    logic        bad;
    logic [31:0] rv;
    int          n;
    rid = 24'($random(seed));
    n   = op[1] ? int'(sz) : 4;
    bad = errNext || (op[1] && (sz == 8'h00 || sz > 8'h04 || rg >= REGS));
    rv  = low(rd(rg), n);
    chan.send(1'h1, hdr[op]);
    for (int i = 2; i >= 0; i--) chan.send(1'h0, rid[i*8+:8]);
    if (!op[1]) chan.send(1'h0, rg[15:8]);
    chan.send(1'h0, rg[7:0]);
    if (op[1]) chan.send(1'h0, sz);
    if (!op[0]) for (int i = n - 1; i >= 0; i--) chan.send(1'h0, dat[(i%4)*8+:8]);
    chan.send(1'h1, cfg_msg_pkg::TOK_END);
    chan.idle();
    exp.push_back({rid, 1'h1, bad ? cfg_msg_pkg::TOK_NACK : cfg_msg_pkg::TOK_ACK});
    if (!bad && op[0]) for (int i = n - 1; i >= 0; i--) exp.push_back({rid, 1'h0, rv[i*8+:8]});
    exp.push_back({rid, 1'h1, cfg_msg_pkg::TOK_END});
    if (!bad && !op[0]) refm[rg] = low(dat, n);
    drain();
  endtask

  task automatic ps(input logic w, input logic [7:0] rg, input logic [31:0] dat);
    int k;
    @(negedge ref_clk);
    psValid = 1'h1;
    psWrite = w;
    psReg   = rg;
    psWdata = dat;
    do @(posedge ref_clk); while (!psReady);
    @(negedge ref_clk);
    psValid = 1'h0;
    psWdata = ~dat;
    k = 0;
    do @(posedge ref_clk); while (!psDone && ++k < 200);
    @(negedge ref_clk);
    cmpWord("status done", 32'h1, 32'(k < 200));
    if (w) refm[{rg, 8'h0C}] = dat;
    else cmpWord("status word", rd({rg, 8'h0C}), psRdata);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge ref_clk);
    cmpTok("reset token", {24'h0, 1'h1, cfg_msg_pkg::TOK_END}, {outDest, outTok});
    @(negedge ref_clk);
    rst_b = 1'h1;
    // Corners: refused write keeps old value, last legal register, widest size
    errNext = 1'h1;
    msg(2'h0, 16'h1003, 8'h04, 32'hFFFFFFFF);
    errNext = 1'h0;
    msg(2'h1, 16'h1003, 8'h04, 32'h0);
    msg(2'h2, 16'h00C7, 8'h04, 32'hA1B2C3D4);
    msg(2'h3, 16'h00C7, 8'h01, 32'h0);
    msg(2'h3, 16'h00C8, 8'h04, 32'h0);
    // Random mix; status words are read back through the config path too
    for (int i = 0; i < 90; i++) begin
      r = $random(seed);
      errNext = r[7:4] == 4'h0 && r[20:18] != 3'h0;
      if (r[20:18] == 3'h0) ps(r[2], {4'h0, r[15:12]}, $random(seed));
      else if (r[1]) msg(r[1:0], {8'h00, r[17:16] == 2'h0 ? 8'hC8 : {4'h0, r[15:12]}},
                         {5'h00, r[10:8]}, $random(seed));
      else msg(r[1:0], r[3] ? {12'h100, r[15:12]} : {4'h0, r[15:12], 8'h0C}, 8'h04,
               $random(seed));
    end
    errNext = 1'h0;
    // Unknown header is drained without reply; early end after the id fails
    chan.send(1'h1, 8'h55);
    chan.send(1'h0, 8'h12);
    chan.send(1'h1, cfg_msg_pkg::TOK_END);
    chan.idle();
    repeat (30) @(posedge ref_clk);
    cmpWord("silent reply count", 32'h0, 32'(chan.got.size()));
    chan.send(1'h1, cfg_msg_pkg::TOK_CFG_READ);
    for (int i = 0; i < 3; i++) chan.send(1'h0, 8'hAB);
    chan.send(1'h1, cfg_msg_pkg::TOK_END);
    chan.idle();
    exp.push_back({24'hABABAB, 1'h1, cfg_msg_pkg::TOK_NACK});
    exp.push_back({24'hABABAB, 1'h1, cfg_msg_pkg::TOK_END});
    drain();
    summarize();
  end
endmodule // test_config_register_message_handler
